// ### reqm_pkg.sv
package reqm_pkg;
    localparam logic [7:0] REQM_OFS_BOOST = 8'h03;
    localparam logic [7:0] REQM_OFS_LRBYP = 8'h0D;
    localparam logic [7:0] REQM_OFS_CFG = 8'h13;
    localparam logic [7:0] REQM_OFS_OVR = 8'h2D;
    localparam logic [7:0] REQM_OFS_MUX = 8'h31;
    localparam logic [7:0] REQM_OFS_APPLIED = 8'h52;
    localparam logic [7:0] REQM_OFS_STATUS = 8'h54;
    localparam logic [7:0] REQM_OFS_MASK = 8'h56;
    localparam logic [7:0] REQM_OFS_GLOBAL = 8'hFF;
    localparam logic [7:0] REQM_RST_BOOST = 8'h80;
    localparam logic [7:0] REQM_RST_LRBYP = 8'h00;
    localparam logic [7:0] REQM_RST_CFG = 8'h90;
    localparam logic [7:0] REQM_RST_OVR = 8'h88;
    localparam logic [7:0] REQM_RST_MUX = 8'h00;
    localparam logic [7:0] REQM_RST_MASK = 8'h00;
    localparam logic [7:0] REQM_RST_GLOBAL = 8'h00;
    localparam int REQM_BIT_AUTO_BYP = 0;
    localparam int REQM_BIT_MAN_BYP = 1;
    localparam int REQM_BIT_EQ_PD = 3;
    localparam int REQM_BIT_SD1_PD = 5;
    localparam int REQM_BIT_SD0_PD = 6;
    localparam int REQM_BIT_OVR = 3;
    localparam int REQM_BIT_LOS_SEL = 5;
    localparam int REQM_BIT_SEL_HI = 1;
    // status/mask bit positions
    localparam int REQM_EV_LOCK = 6;
    localparam int REQM_EV_DET1 = 5;
    localparam int REQM_EV_DET0 = 4;
    localparam int REQM_EV_EYE = 3;
    localparam int REQM_EV_LOCKLOSS = 2;
    localparam int REQM_EV_LOSS1 = 1;
    localparam int REQM_EV_LOSS0 = 0;
    localparam int REQM_ST_SIGDET = 7;
endpackage : reqm_pkg

// ### reqm_regs.sv
`timescale 1ns/1ps
module reqm_regs
    import reqm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic adapt_valid_in,
    input wire logic [7:0] adapt_boost_in,
    input wire logic lock_in,
    input wire logic det0_in,
    input wire logic det1_in,
    input wire logic eye_thresh_in,
    output logic [7:0] applied_boost_out,
    output logic low_rate_bypass_out,
    output logic late_stage_bypass_out,
    output logic first_detector_powerdown_out,
    output logic second_detector_powerdown_out,
    output logic first_eq_powerdown_out,
    output logic second_eq_powerdown_out,
    output logic second_input_selected_out,
    output logic irq_out,
    output logic los_pin_out
);
    logic [7:0] eq_stage_boost;
    logic [7:0] low_rate_eq_bypass;
    logic [7:0] eq_bypass_power_config;
    logic [7:0] boost_override_reg;
    logic [7:0] mux_config;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] global_control;
    logic [7:0] int_status;
    logic [1:0] lock_sync;
    logic [1:0] det0_sync;
    logic [1:0] det1_sync;
    logic [1:0] eye_sync;
    logic lock_q;
    logic det0_q;
    logic det1_q;
    logic eye_q;
    logic [7:0] next_rdata;
    logic [6:0] events;
    logic boost_override;
    logic channel_select_hi;
    logic sel_det;
    logic status_read;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge history
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            lock_sync <= 2'h0;
            det0_sync <= 2'h0;
            det1_sync <= 2'h0;
            eye_sync <= 2'h0;
            lock_q <= 1'b0;
            det0_q <= 1'b0;
            det1_q <= 1'b0;
            eye_q <= 1'b0;
        end else begin
            lock_sync <= {lock_sync[0], lock_in};
            det0_sync <= {det0_sync[0], det0_in};
            det1_sync <= {det1_sync[0], det1_in};
            eye_sync <= {eye_sync[0], eye_thresh_in};
            lock_q <= lock_sync[1];
            det0_q <= det0_sync[1];
            det1_q <= det1_sync[1];
            eye_q <= eye_sync[1];
        end
    end

    assign boost_override = boost_override_reg[REQM_BIT_OVR];
    assign channel_select_hi = mux_config[REQM_BIT_SEL_HI];
    assign sel_det = channel_select_hi ? det1_sync[1] : det0_sync[1];
    assign status_read = rd_en_in && (addr_in == REQM_OFS_STATUS);

    always_comb begin
        events = 7'h00;
        events[REQM_EV_LOCK] = lock_sync[1] & ~lock_q;
        events[REQM_EV_DET1] = det1_sync[1] & ~det1_q;
        events[REQM_EV_DET0] = det0_sync[1] & ~det0_q;
        events[REQM_EV_EYE] = eye_sync[1] & ~eye_q;
        events[REQM_EV_LOCKLOSS] = ~lock_sync[1] & lock_q;
        events[REQM_EV_LOSS1] = ~det1_sync[1] & det1_q;
        events[REQM_EV_LOSS0] = ~det0_sync[1] & det0_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            low_rate_eq_bypass <= REQM_RST_LRBYP;
            eq_bypass_power_config <= REQM_RST_CFG;
            boost_override_reg <= REQM_RST_OVR;
            mux_config <= REQM_RST_MUX;
            interrupt_enable_mask <= REQM_RST_MASK;
            global_control <= REQM_RST_GLOBAL;
        end else if (wr_en_in) begin
            unique case (addr_in)
                REQM_OFS_LRBYP: low_rate_eq_bypass <= wdata_in;
                REQM_OFS_CFG: eq_bypass_power_config <= wdata_in;
                REQM_OFS_OVR: boost_override_reg <= wdata_in;
                REQM_OFS_MUX: mux_config <= wdata_in;
                REQM_OFS_MASK: interrupt_enable_mask <= wdata_in;
                REQM_OFS_GLOBAL: global_control <= wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            eq_stage_boost <= REQM_RST_BOOST;
        end else if (wr_en_in && addr_in == REQM_OFS_BOOST) begin
            eq_stage_boost <= wdata_in;
        end else if (adapt_valid_in && !boost_override) begin
            eq_stage_boost <= adapt_boost_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status bits 6:0, set beats read clear; bit 7 follows the selected detect
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            int_status <= 8'h00;
        end else begin
            int_status[6:0] <= (status_read ? 7'h00 : int_status[6:0]) | events;
            int_status[REQM_ST_SIGDET] <= sel_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        unique case (addr_in)
            REQM_OFS_BOOST: next_rdata = eq_stage_boost;
            REQM_OFS_LRBYP: next_rdata = low_rate_eq_bypass;
            REQM_OFS_CFG: next_rdata = eq_bypass_power_config;
            REQM_OFS_OVR: next_rdata = boost_override_reg;
            REQM_OFS_MUX: next_rdata = mux_config;
            REQM_OFS_APPLIED: next_rdata = applied_boost_out;
            REQM_OFS_STATUS: next_rdata = int_status;
            REQM_OFS_MASK: next_rdata = interrupt_enable_mask;
            REQM_OFS_GLOBAL: next_rdata = global_control;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_en_in) begin
            rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // equalizer controls
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            applied_boost_out <= REQM_RST_BOOST;
            low_rate_bypass_out <= 1'b0;
            late_stage_bypass_out <= 1'b0;
            first_detector_powerdown_out <= 1'b0;
            second_detector_powerdown_out <= 1'b0;
            first_eq_powerdown_out <= 1'b1;
            second_eq_powerdown_out <= 1'b1;
            second_input_selected_out <= 1'b0;
        end else begin
            applied_boost_out <= boost_override ? eq_stage_boost : adapt_boost_in;
            low_rate_bypass_out <= low_rate_eq_bypass[REQM_BIT_AUTO_BYP]
                | eq_bypass_power_config[REQM_BIT_MAN_BYP];
            late_stage_bypass_out <= eq_bypass_power_config[REQM_BIT_MAN_BYP];
            first_detector_powerdown_out <= eq_bypass_power_config[REQM_BIT_SD0_PD];
            second_detector_powerdown_out <= eq_bypass_power_config[REQM_BIT_SD1_PD];
            // selected eq powered unless the eq power-down bit is set, other always down
            first_eq_powerdown_out <= channel_select_hi
                | eq_bypass_power_config[REQM_BIT_EQ_PD];
            second_eq_powerdown_out <= !channel_select_hi
                | eq_bypass_power_config[REQM_BIT_EQ_PD];
            second_input_selected_out <= channel_select_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt level, loss pin select
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
            los_pin_out <= 1'b0;
        end else begin
            irq_out <= |(int_status[6:0] & interrupt_enable_mask[6:0]);
            los_pin_out <= global_control[REQM_BIT_LOS_SEL]
                ? |(int_status[6:0] & interrupt_enable_mask[6:0]) : sel_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    lock_irq_a: assert property (events[REQM_EV_LOCK]
        && interrupt_enable_mask[REQM_EV_LOCK]
        && !(wr_en_in && addr_in == REQM_OFS_MASK) |=> ##1 irq_out)
        else $error("lock event did not raise irq");
    lock_latch_a: assert property (events[REQM_EV_LOCK] |=> int_status[REQM_EV_LOCK])
        else $error("lock event not latched");
    lock_gate_a: assert property (int_status[REQM_EV_LOCK]
        && interrupt_enable_mask[REQM_EV_LOCK] |=> irq_out)
        else $error("enabled lock flag without irq");
    det_latch_a: assert property (events[REQM_EV_DET1] |=> int_status[REQM_EV_DET1])
        else $error("detect event not latched");
    det0_latch_a: assert property (events[REQM_EV_DET0] |=> int_status[REQM_EV_DET0])
        else $error("first input detect not latched");
    det_gate_a: assert property (int_status[REQM_EV_DET1]
        && interrupt_enable_mask[REQM_EV_DET1] |=> irq_out)
        else $error("enabled detect flag without irq");
    eye_latch_a: assert property (events[REQM_EV_EYE] |=> int_status[REQM_EV_EYE])
        else $error("eye event not latched");
    eye_gate_a: assert property (int_status[REQM_EV_EYE]
        && interrupt_enable_mask[REQM_EV_EYE] |=> irq_out)
        else $error("enabled eye flag without irq");
    irq_masked_a: assert property ((int_status[6:0] & interrupt_enable_mask[6:0]) == 7'h00
        |=> !irq_out)
        else $error("irq high with nothing enabled");
    lockloss_latch_a: assert property (events[REQM_EV_LOCKLOSS]
        |=> int_status[REQM_EV_LOCKLOSS])
        else $error("loss of lock not latched");
    lockloss_gate_a: assert property (int_status[REQM_EV_LOCKLOSS]
        && interrupt_enable_mask[REQM_EV_LOCKLOSS] |=> irq_out)
        else $error("enabled lock loss flag without irq");
    loss_latch_a: assert property (events[REQM_EV_LOSS0] |=> int_status[REQM_EV_LOSS0])
        else $error("loss event not latched");
    loss1_latch_a: assert property (events[REQM_EV_LOSS1] |=> int_status[REQM_EV_LOSS1])
        else $error("second input loss not latched");
    loss_gate_a: assert property (int_status[REQM_EV_LOSS0]
        && interrupt_enable_mask[REQM_EV_LOSS0] |=> irq_out)
        else $error("enabled loss flag without irq");
    boost_write_a: assert property (wr_en_in && addr_in == REQM_OFS_BOOST
        |=> eq_stage_boost == $past(wdata_in))
        else $error("boost register write lost");
    adapt_store_a: assert property (adapt_valid_in && !boost_override
        && !(wr_en_in && addr_in == REQM_OFS_BOOST)
        |=> eq_stage_boost == $past(adapt_boost_in))
        else $error("adapted boost not stored");
    override_a: assert property (boost_override
        |=> applied_boost_out == $past(eq_stage_boost))
        else $error("override not applied");
    boost_hold_a: assert property (boost_override
        && !(wr_en_in && addr_in == REQM_OFS_BOOST) |=> $stable(eq_stage_boost))
        else $error("boost changed under override");
    applied_read_a: assert property (rd_en_in && addr_in == REQM_OFS_APPLIED
        |=> rdata_out == $past(applied_boost_out))
        else $error("applied boost readback wrong");
    auto_byp_a: assert property (low_rate_eq_bypass[REQM_BIT_AUTO_BYP]
        |=> low_rate_bypass_out)
        else $error("auto bypass not in force");
    no_byp_a: assert property (!low_rate_eq_bypass[REQM_BIT_AUTO_BYP]
        && !eq_bypass_power_config[REQM_BIT_MAN_BYP] |=> !low_rate_bypass_out)
        else $error("bypass without a bypass bit");
    manual_byp_a: assert property (eq_bypass_power_config[REQM_BIT_MAN_BYP]
        |=> low_rate_bypass_out && late_stage_bypass_out)
        else $error("manual bypass not in force");
    late_on_a: assert property (!eq_bypass_power_config[REQM_BIT_MAN_BYP]
        |=> !late_stage_bypass_out)
        else $error("late stages bypassed without manual bit");
    det0_pd_a: assert property (eq_bypass_power_config[REQM_BIT_SD0_PD]
        |=> first_detector_powerdown_out)
        else $error("first detector not powered down");
    det1_pd_a: assert property (!eq_bypass_power_config[REQM_BIT_SD1_PD]
        |=> !second_detector_powerdown_out)
        else $error("second detector powered down");
    sel_eq_on_a: assert property (!channel_select_hi
        && !eq_bypass_power_config[REQM_BIT_EQ_PD] |=> !first_eq_powerdown_out)
        else $error("selected first equalizer not powered");
    sel2_eq_on_a: assert property (channel_select_hi
        && !eq_bypass_power_config[REQM_BIT_EQ_PD] |=> !second_eq_powerdown_out)
        else $error("selected second equalizer not powered");
    sel_eq_off_a: assert property (eq_bypass_power_config[REQM_BIT_EQ_PD]
        |=> first_eq_powerdown_out && second_eq_powerdown_out)
        else $error("equalizer power down ignored");
    unsel_pd_a: assert property (channel_select_hi |=> first_eq_powerdown_out)
        else $error("unselected first equalizer powered");
    unsel2_pd_a: assert property (!channel_select_hi |=> second_eq_powerdown_out)
        else $error("unselected second equalizer powered");
    read_clear_a: assert property (status_read && events == 7'h00
        |=> int_status[6:0] == 7'h00)
        else $error("status not cleared by read");
    status_data_a: assert property (status_read |=> rdata_out == $past(int_status))
        else $error("status read data wrong");
    select_a: assert property (channel_select_hi |=> second_input_selected_out)
        else $error("second input not selected");
    los_det_a: assert property (!global_control[REQM_BIT_LOS_SEL]
        |=> los_pin_out == $past(sel_det))
        else $error("loss pin not showing detect");
    irq_clear_a: assert property (status_read && events == 7'h00
        |=> ##1 !irq_out)
        else $error("irq held after status read");

    lock_irq_c: cover property (events[REQM_EV_LOCK] ##2 irq_out);
    read_clear_c: cover property (irq_out ##1 status_read ##2 !irq_out);
    adapt_c: cover property (adapt_valid_in && !boost_override);
    hold_c: cover property (adapt_valid_in && boost_override);
    los_irq_c: cover property (global_control[REQM_BIT_LOS_SEL] && los_pin_out);
endmodule : reqm_regs

// ### reqm_regs_tb_top.sv
`timescale 1ns/1ps
module reqm_regs_tb_top
    import reqm_pkg::*;
;
logic clk_sys_in = 1'b0;
logic rst_in = 1'b1;
logic wr_en_in = 1'b0;
logic rd_en_in = 1'b0;
logic adapt_valid_in = 1'b0;
logic lock_in = 1'b0;
logic det0_in = 1'b0;
logic det1_in = 1'b0;
logic eye_thresh_in = 1'b0;
logic [7:0] addr_in = 8'h00;
logic [7:0] wdata_in = 8'h00;
logic [7:0] adapt_boost_in = 8'h00;
logic [7:0] rdata_out;
logic [7:0] applied_boost_out;
logic low_rate_bypass_out, late_stage_bypass_out, first_detector_powerdown_out;
logic second_detector_powerdown_out, first_eq_powerdown_out, second_eq_powerdown_out;
logic second_input_selected_out, irq_out, los_pin_out;
int miscompares = 0;
int comparisons = 0;
logic [7:0] ofs[4] = '{REQM_OFS_BOOST, REQM_OFS_LRBYP, REQM_OFS_CFG, REQM_OFS_MASK};
logic [7:0] rst[4] = '{REQM_RST_BOOST, REQM_RST_LRBYP, REQM_RST_CFG, REQM_RST_MASK};
logic [7:0] t_lr[7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
logic [7:0] t_cfg[7] = '{8'h90, 8'h92, 8'h92, 8'h90, 8'hC8, 8'hB8, 8'h90};
logic [7:0] t_mux[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h03, 8'h00};
logic [7:0] t_exp[7] = '{8'h42, 8'h62, 8'h65, 8'h05, 8'h16, 8'h0F, 8'h02};
// input levels {eye, det1, det0, lock} and the event bit each step raises
logic [3:0] t_in[7] = '{4'h1, 4'h0, 4'h2, 4'h0, 4'h4, 4'h0, 4'h8};
logic [7:0] t_ev[7] = '{8'h40, 8'h04, 8'h10, 8'h01, 8'h20, 8'h02, 8'h08};
logic [7:0] outs;

reqm_regs reqm_regs_i (
    .clk_sys_in, .rst_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in, .rdata_out,
    .adapt_valid_in, .adapt_boost_in, .lock_in, .det0_in, .det1_in, .eye_thresh_in,
    .applied_boost_out, .low_rate_bypass_out, .late_stage_bypass_out,
    .first_detector_powerdown_out, .second_detector_powerdown_out,
    .first_eq_powerdown_out, .second_eq_powerdown_out,
    .second_input_selected_out, .irq_out, .los_pin_out
);

always #12.5 clk_sys_in = ~clk_sys_in;

assign outs = {1'b0, low_rate_bypass_out, late_stage_bypass_out,
    first_detector_powerdown_out, second_detector_powerdown_out,
    first_eq_powerdown_out, second_eq_powerdown_out, second_input_selected_out};

////////////////////////////////////////////////////////////////////////////////
task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
endtask : cyc

task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
        miscompares++;
        $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
endtask : chk

task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in = a;
    wdata_in = d;
    wr_en_in = 1'b1;
    cyc(1);
    wr_en_in = 1'b0;
    cyc(1);
endtask : wr

task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_in = a;
    rd_en_in = 1'b1;
    cyc(1);
    rd_en_in = 1'b0;
    cyc(1);
    chk(rdata_out, exp, "read");
endtask : rd

task automatic adapt(input logic [7:0] v);
    adapt_boost_in = v;
    adapt_valid_in = 1'b1;
    cyc(1);
    adapt_valid_in = 1'b0;
    cyc(1);
endtask : adapt

task automatic close_out();
    if (miscompares == 0 && comparisons > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask : close_out

////////////////////////////////////////////////////////////////////////////////
initial begin
    cyc(3);
    rst_in = 1'b0;
    cyc(1);
    for (int i = 0; i < 4; i++) begin
        rd(ofs[i], rst[i]);
        wr(ofs[i], 8'h3C);
        rd(ofs[i], 8'h3C);
        wr(ofs[i], rst[i]);
    end
    rd(REQM_OFS_OVR, REQM_RST_OVR);
    rd(REQM_OFS_MUX, REQM_RST_MUX);
    rd(REQM_OFS_GLOBAL, REQM_RST_GLOBAL);
    // unmapped and read-only places
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(REQM_OFS_STATUS, 8'hFF);
    rd(REQM_OFS_STATUS, 8'h00);
    chk(applied_boost_out, REQM_RST_BOOST, "boost");
    for (int i = 0; i < 7; i++) begin
        wr(REQM_OFS_LRBYP, t_lr[i]);
        wr(REQM_OFS_CFG, t_cfg[i]);
        wr(REQM_OFS_MUX, t_mux[i]);
        cyc(1);
        chk(outs, t_exp[i], "ctrl");
    end
    // override on at reset: adaptation must not touch the boost register
    wr(REQM_OFS_BOOST, 8'h5A);
    adapt(8'hC3);
    rd(REQM_OFS_BOOST, 8'h5A);
    chk(applied_boost_out, 8'h5A, "applied");
    rd(REQM_OFS_APPLIED, 8'h5A);
    wr(REQM_OFS_OVR, 8'h80);
    adapt(8'h27);
    chk(applied_boost_out, 8'h27, "applied");
    rd(REQM_OFS_BOOST, 8'h27);
    rd(REQM_OFS_APPLIED, 8'h27);
    // each event alone, enabled on even steps, masked out on odd ones
    for (int i = 0; i < 7; i++) begin
        wr(REQM_OFS_MASK, i[0] ? (8'h7F ^ t_ev[i]) : t_ev[i]);
        {eye_thresh_in, det1_in, det0_in, lock_in} = t_in[i];
        cyc(8);
        chk({7'h00, irq_out}, {7'h00, ~i[0]}, "irq");
        rd(REQM_OFS_STATUS, {t_in[i][1], 7'h00} | t_ev[i]);
        cyc(1);
        chk({7'h00, irq_out}, 8'h00, "irq clr");
        rd(REQM_OFS_STATUS, {t_in[i][1], 7'h00});
    end
    det0_in = 1'b1;
    cyc(8);
    chk({7'h00, los_pin_out}, 8'h01, "los det");
    wr(REQM_OFS_GLOBAL, 8'h20);
    cyc(1);
    chk({7'h00, los_pin_out}, 8'h00, "los irq");
    wr(REQM_OFS_MASK, 8'h10);
    cyc(2);
    chk({7'h00, los_pin_out}, 8'h01, "los irq");
    close_out();
end

endmodule : reqm_regs_tb_top
